//--- dv/sspc_peer.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Slave peer on the far side of the link. It gathers the bits that the block
// sends out.
module sspc_peer (
  // Link pins as the peer sees them.
  input wire logic sck,
  input wire logic mosi,
  // Last byte gathered, first bit in ends up as the top bit.
  output logic [7:0] rx
);
  ////////////////////////////////////////////////////////////////////////////////
  // The block moves data together with the rising pin edge, so sampling there
  // would race; the falling edge sits mid-bit and is the safe point.
  always @(negedge sck) begin
    rx <= {rx[6:0], mosi};
  end
  // Start from a known byte so that a missing transfer cannot match by chance.
  initial begin
    rx = 8'h00;
  end
endmodule : sspc_peer

//--- dv/sspc_top_tb.sv
`timescale 1ns/10ps
module sspc_top_tb;
  import sspc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic conflict = 1'b0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, sck_o, sck_oe, cs_o, cs_oe, sdo, sck_w, cs_w;
  logic [7:0] rx;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and the pin wires: both lines carry a pull-up when nobody drives.
  always #10 clk_sys = ~clk_sys;
  assign sck_w = sck_oe ? sck_o : 1'b1;
  assign cs_w = cs_oe ? cs_o : 1'b1;
  sspc_top #(.DIV(2)) dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .WB_CYC(cyc),
    .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'h1), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK(ack), .SERIAL_CLOCK_PIN_I(sck_w),
    .SERIAL_CLOCK_PIN_O(sck_o), .SERIAL_CLOCK_PIN_OE(sck_oe),
    .CHIP_SELECT_PIN_I(cs_w), .CHIP_SELECT_PIN_O(cs_o),
    .CHIP_SELECT_PIN_OE(cs_oe), .SERIAL_DATA_OUT_PIN(sdo),
    .CONFLICT_ERR_I(conflict));
  sspc_peer peer (.sck(sck_w), .mosi(sdo), .rx(rx));
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict in one place, reached by the main sequence or by the timeout.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // Four-state compare, so an unknown never passes.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    check(what, rdat, exp);
  endtask : rd
  // Let registered pin updates land before looking at them.
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  // Poll the busy flag so that no level write lands mid-transfer.
  task automatic wait_idle;
    do wb(1'b0, 4'h4, 32'h0); while (rdat[1] !== 1'b0);
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////////
  // A hang counts against the run and still ends in the verdict.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(4'h0, 32'h08, "ctrl reset");
    wb(1'b1, 4'h0, 32'h18);
    settle();
    check("protected level", sdo, 32'h0);
    rd(4'h0, 32'h08, "ctrl protected");
    wb(1'b1, 4'h0, 32'h10);
    settle();
    check("level high", sdo, 32'h1);
    rd(4'h0, 32'h18, "ctrl level");
    wb(1'b1, 4'h0, 32'h00);
    settle();
    check("level low", sdo, 32'h0);
    $display("test level done");
    wb(1'b1, 4'h0, 32'h80);
    settle();
    check("clock as port", sck_oe, 32'h0);
    wb(1'b1, 4'h0, 32'h84);
    settle();
    check("clock driven", sck_oe, 32'h1);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 4'h0, 32'h84 | m);
      settle();
      check("cs idle oe", cs_oe, (m == 3));
      if (m == 3) check("cs idle high", cs_o, 32'h1);
      wb(1'b1, 4'h8, 32'h81 | (m << 4));
      settle();
      check("cs busy oe", cs_oe, (m >= 2));
      if (m >= 2) check("cs busy low", cs_o, 32'h0);
      wait_idle();
      settle();
      check("peer byte", rx, 32'h81 | (m << 4));
      check("last bit held", sdo, 32'h1);
      check("cs after oe", cs_oe, (m == 3));
      if (m == 3) check("cs after high", cs_o, 32'h1);
    end
    $display("test chip select done");
    wb(1'b1, 4'h0, 32'h07);
    settle();
    check("slave cs oe", cs_oe, 32'h0);
    check("slave clock oe", sck_oe, 32'h0);
    wb(1'b1, 4'h0, 32'h87);
    @(posedge clk_sys);
    conflict <= 1'b1;
    repeat (4) @(posedge clk_sys);
    conflict <= 1'b0;
    rd(4'h0, 32'h0f, "ctrl after conflict");
    rd(4'h4, 32'h0d, "status after conflict");
    rd(4'hc, 32'h0, "unmapped");
    // Clearing the sticky flag, then a transfer write that slave mode refuses.
    wb(1'b1, 4'h4, 32'h0);
    rd(4'h4, 32'h0c, "status cleared");
    wb(1'b1, 4'h8, 32'h55);
    rd(4'h4, 32'h0c, "slave no start");
    rd(4'h8, 32'h55, "transfer data");
    // A protected write keeps the level and stores the other fields.
    wb(1'b1, 4'h0, 32'h4c);
    rd(4'h0, 32'h4c, "bidir stored");
    $display("test modes done");
    end_of_test();
  end
endmodule : sspc_top_tb

//--- hw/sspc_map.svh
// Notes on behaviour
// - Data output holds last shifted bit after transfer.
// - Permitted write of level drives idle output.
// - Level write ignored unless protect bit zero.
// - Protect bit always reads back as one.
// - Clock select zero port, one serial clock.
// - Select 00 port, 01 chip-select input.
// - Select 10 input idle, low in transfer.
// - Select 11 high idle, low in transfer.
// - Slave mode forces chip-select pin to input.
// - Master with clock select one drives clock; conflict clears master bit.
`ifndef SSPC_MAP_SVH
`define SSPC_MAP_SVH
`define SSPC_ADDR_CTRL_H 4'h0
`define SSPC_ADDR_STATUS 4'h4
`define SSPC_ADDR_TRANSFER 4'h8
`define SSPC_BIT_MSS 7
`define SSPC_BIT_BIDIR 6
`define SSPC_BIT_LEVEL 4
`define SSPC_BIT_PROT 3
`define SSPC_BIT_CKS 2
`define SSPC_BIT_CS_HI 1
`define SSPC_BIT_CS_LO 0
`define SSPC_BIT_CONFLICT 0
`define SSPC_CTRL_RESET 8'h08
`define SSPC_CS_PORT 2'h0
`define SSPC_CS_IN 2'h1
`define SSPC_CS_AUTO_IO 2'h2
`define SSPC_CS_AUTO_OUT 2'h3
`define SSPC_DIV_DEFAULT 8
`endif

//--- hw/sspc_pkg.sv
package sspc_pkg;
  // Output and output enable of a two-way pin.
  typedef struct packed {
    logic o;
    logic oe;
  } sspc_pin_drive_t;
  // Transfer sequencer states.
  typedef enum logic [1:0] {
    SSPC_IDLE,
    SSPC_SHIFT,
    SSPC_DONE
  } sspc_state_t;
endpackage : sspc_pkg

//--- hw/sspc_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for pin inputs; the first stage feeds only the second.
module sspc_sync
  import sspc_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous input and its synchronised copy.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1; // First stage, read only by the second.

  // Each bit is caught twice to settle metastability.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : sspc_sync

//--- hw/sspc_top.sv
`timescale 1ns/10ps
`include "sspc_map.svh"
// Pin control for a synchronous serial unit: idle data level, clock pin
// and chip-select pin functions. A minimal master shifter drives transfers
// so the pin behaviour has something to follow.
module sspc_top
  import sspc_pkg::*;
#(
  parameter int DIV = `SSPC_DIV_DEFAULT
) (
  // System clock and reset.
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Wishbone classic slave.
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [3:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // Serial clock pin.
  input wire logic SERIAL_CLOCK_PIN_I,
  output logic SERIAL_CLOCK_PIN_O,
  output logic SERIAL_CLOCK_PIN_OE,
  // Chip-select pin.
  input wire logic CHIP_SELECT_PIN_I,
  output logic CHIP_SELECT_PIN_O,
  output logic CHIP_SELECT_PIN_OE,
  // Serial data output pin.
  output logic SERIAL_DATA_OUT_PIN,
  // Conflict-error input from the peer watch logic.
  input wire logic CONFLICT_ERR_I
);
  ////////////////////////////////////////////////////////////////////////////
  // Control register fields.
  logic master_slave_select; // 1 master, 0 slave.
  logic bidir_mode; // Stored only.
  logic data_out_level; // Programmed idle level.
  logic clock_pin_select; // 1 serial clock function.
  logic [1:0] chip_select_func; // Chip-select pin function.
  logic level_load; // Pulses when a permitted level write lands.
  logic conflict_flag; // Sticky conflict status.
  logic [7:0] tx_byte; // Byte to shift.
  logic start_req; // Transfer start pulse.
  logic [2:0] pins_sync; // Synchronised pin inputs.
  logic cs_in_sync; // Synchronised chip-select input.
  logic sck_in_sync; // Synchronised clock input, visible as a port.
  logic conflict_sync; // Synchronised conflict input.
  logic conflict_prev; // Edge detect of conflict.
  logic wb_req; // Fresh bus request.
  sspc_state_t state; // Sequencer state.
  logic [2:0] bit_cnt; // Bits remaining after the current one.
  logic [$clog2(DIV)-1:0] div_cnt; // Half-period divider.
  logic tick; // Half-period enable pulse.
  logic sck_phase; // Serial clock level during transfer.
  logic [7:0] shift; // Shift register.
  logic busy; // Transfer in progress.
  logic [7:0] ctrl_rd; // Read view of control.

  assign wb_req = WB_CYC && WB_STB && !WB_ACK;
  assign busy = (state != SSPC_IDLE);
  assign cs_in_sync = pins_sync[0];
  assign sck_in_sync = pins_sync[1];
  assign conflict_sync = pins_sync[2];
  assign tick = (div_cnt == '0);

  // Pins from outside pass two flops before use.
  sspc_sync #(.WIDTH(3)) u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .async_in({CONFLICT_ERR_I, SERIAL_CLOCK_PIN_I, CHIP_SELECT_PIN_I}),
    .sync_out(pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register writes; protect bit is write-only in effect.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      master_slave_select <= 1'b0;
      bidir_mode <= 1'b0;
      data_out_level <= 1'b0;
      clock_pin_select <= 1'b0;
      chip_select_func <= `SSPC_CS_PORT;
      level_load <= 1'b0;
    end else begin
      level_load <= 1'b0;
      if (wb_req && WB_WE && WB_SEL[0] && WB_ADR == `SSPC_ADDR_CTRL_H) begin
        master_slave_select <= WB_DAT_I[`SSPC_BIT_MSS];
        bidir_mode <= WB_DAT_I[`SSPC_BIT_BIDIR];
        clock_pin_select <= WB_DAT_I[`SSPC_BIT_CKS];
        chip_select_func <= WB_DAT_I[`SSPC_BIT_CS_HI:`SSPC_BIT_CS_LO];
        // Level changes only when the same write clears the protect bit.
        if (!WB_DAT_I[`SSPC_BIT_PROT]) begin
          data_out_level <= WB_DAT_I[`SSPC_BIT_LEVEL];
          level_load <= 1'b1;
        end
      end
      // A conflict edge beats the write and drops to slave.
      if (conflict_sync && !conflict_prev) begin
        master_slave_select <= 1'b0;
      end
    end
  end

  // Conflict status: set wins over the clear write.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      conflict_prev <= 1'b0;
      conflict_flag <= 1'b0;
    end else begin
      conflict_prev <= conflict_sync;
      if (conflict_sync && !conflict_prev) begin
        conflict_flag <= 1'b1;
      end else if (wb_req && WB_WE && WB_SEL[0] && WB_ADR == `SSPC_ADDR_STATUS) begin
        conflict_flag <= conflict_flag & WB_DAT_I[`SSPC_BIT_CONFLICT];
      end
    end
  end

  // Transfer data register; a write in master mode while idle starts a transfer.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_byte <= 8'h00;
      start_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (wb_req && WB_WE && WB_SEL[0] && WB_ADR == `SSPC_ADDR_TRANSFER) begin
        tx_byte <= WB_DAT_I[7:0];
        start_req <= master_slave_select && !busy;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: ack one cycle after the request, registered read data.
  assign ctrl_rd = {master_slave_select, bidir_mode, 1'b0, data_out_level,
                    1'b1, clock_pin_select, chip_select_func};
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      WB_ACK <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req && !WB_WE) begin
        unique case (WB_ADR)
          `SSPC_ADDR_CTRL_H: WB_DAT_O <= {24'h000000, ctrl_rd};
          `SSPC_ADDR_STATUS: WB_DAT_O <= {28'h0, cs_in_sync, sck_in_sync, busy, conflict_flag};
          `SSPC_ADDR_TRANSFER: WB_DAT_O <= {24'h000000, tx_byte};
          default: WB_DAT_O <= 32'h0000_0000; // Unmapped reads as zero.
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider; restarts at each transfer start.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_cnt <= '0;
    end else if (start_req || tick) begin
      div_cnt <= ($clog2(DIV))'(DIV - 1);
    end else begin
      div_cnt <= div_cnt - 1'b1;
    end
  end

  // Sequencer: eight bits, MSB first, clock idles high.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= SSPC_IDLE;
      bit_cnt <= 3'h0;
      sck_phase <= 1'b1;
      shift <= 8'h00;
    end else begin
      unique case (state)
        SSPC_IDLE: begin
          sck_phase <= 1'b1;
          if (start_req) begin
            shift <= tx_byte;
            bit_cnt <= 3'h7;
            state <= SSPC_SHIFT;
          end
        end
        SSPC_SHIFT: begin
          if (tick) begin
            sck_phase <= !sck_phase;
            if (!sck_phase) begin
              if (bit_cnt == 3'h0) begin
                state <= SSPC_DONE;
              end else begin
                bit_cnt <= bit_cnt - 1'b1;
                shift <= {shift[6:0], 1'b0};
              end
            end
          end
        end
        SSPC_DONE: begin
          sck_phase <= 1'b1;
          state <= SSPC_IDLE;
        end
      endcase
    end
  end

  // Data pin: bit during shift, holds last bit after, programmed level on load.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      SERIAL_DATA_OUT_PIN <= 1'b0;
    end else if (state == SSPC_SHIFT) begin
      SERIAL_DATA_OUT_PIN <= shift[7];
    end else if (level_load) begin
      SERIAL_DATA_OUT_PIN <= data_out_level;
    end
    // Otherwise the last shifted bit stays until a permitted level write.
  end

  // Clock pin: driven only in serial-clock function and master mode.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      SERIAL_CLOCK_PIN_O <= 1'b1;
      SERIAL_CLOCK_PIN_OE <= 1'b0;
    end else begin
      SERIAL_CLOCK_PIN_O <= sck_phase;
      SERIAL_CLOCK_PIN_OE <= clock_pin_select && master_slave_select;
    end
  end

  // Chip-select pin; slave mode forces input whatever the field says.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      CHIP_SELECT_PIN_O <= 1'b1;
      CHIP_SELECT_PIN_OE <= 1'b0;
    end else if (!master_slave_select) begin
      CHIP_SELECT_PIN_O <= 1'b1;
      CHIP_SELECT_PIN_OE <= 1'b0;
    end else begin
      unique case (chip_select_func)
        `SSPC_CS_PORT, `SSPC_CS_IN: begin
          CHIP_SELECT_PIN_O <= 1'b1;
          CHIP_SELECT_PIN_OE <= 1'b0;
        end
        `SSPC_CS_AUTO_IO: begin
          CHIP_SELECT_PIN_O <= 1'b0;
          CHIP_SELECT_PIN_OE <= busy;
        end
        `SSPC_CS_AUTO_OUT: begin
          CHIP_SELECT_PIN_O <= !busy;
          CHIP_SELECT_PIN_OE <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_level_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (wb_req && WB_WE && WB_SEL[0] && WB_ADR == `SSPC_ADDR_CTRL_H && WB_DAT_I[`SSPC_BIT_PROT])
    |=> $stable(data_out_level)) else $error("protected level changed");
  a_level_drive: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (level_load && state != SSPC_SHIFT) |=> SERIAL_DATA_OUT_PIN == $past(data_out_level))
    else $error("idle level not driven");
  a_level_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == SSPC_IDLE && !level_load) |=> $stable(SERIAL_DATA_OUT_PIN))
    else $error("idle data changed");
  a_prot_read: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (wb_req && !WB_WE && WB_ADR == `SSPC_ADDR_CTRL_H) |=> WB_DAT_O[`SSPC_BIT_PROT])
    else $error("protect bit read zero");
  a_clock_port: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !clock_pin_select |=> !SERIAL_CLOCK_PIN_OE) else $error("clock pin driven as port");
  a_cs_slave: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !master_slave_select |=> !CHIP_SELECT_PIN_OE) else $error("slave drives select");
  a_cs_input: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (chip_select_func == `SSPC_CS_IN) |=> !CHIP_SELECT_PIN_OE) else $error("input drives");
  a_cs_autoio: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (master_slave_select && chip_select_func == `SSPC_CS_AUTO_IO)
    |=> CHIP_SELECT_PIN_OE == $past(busy) && !CHIP_SELECT_PIN_O) else $error("auto io wrong");
  a_cs_autoout: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (master_slave_select && chip_select_func == `SSPC_CS_AUTO_OUT)
    |=> CHIP_SELECT_PIN_OE && CHIP_SELECT_PIN_O == !$past(busy)) else $error("auto out wrong");
  a_conflict_slave: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (conflict_sync && !conflict_prev) |=> !master_slave_select && conflict_flag)
    else $error("conflict kept master");
  c_transfer: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    state == SSPC_SHIFT ##[1:300] state == SSPC_DONE);
  c_level_load: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) level_load);
  c_auto_out: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    CHIP_SELECT_PIN_OE && !CHIP_SELECT_PIN_O);
endmodule : sspc_top
